// >>> channel_config_fields.sv
// Per-channel configuration register bank with setup select, low-side switch control
// and positive input select, reached over APB.
// Assumes a conversion sequencer that reports the channel it is working on and whether
// a conversion is running; the power mode and standby switch allowance come from a
// power control register in this bank.
`timescale 1ns/1ns
`default_nettype none
`include "channel_cfg_defs.svh"

module channel_config_fields #(
	parameter int NUM_CHAN  = `CCF_NUM_CHAN,
	parameter int NUM_BANKS = 8
) (
	input  wire logic                       i_core_clk,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [7:0]                 i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic      [31:0]                o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic [3:0]                 i_active_chan,
	input  wire logic                       i_chan_converting,
	output logic                            o_low_side_switch_pin_close,
	output logic      [NUM_BANKS-1:0]       o_setup_bank_sel,
	output logic      [2:0]                 o_setup_code,
	output logic      [4:0]                 o_positive_input_select,
	output channel_cfg_pkg::pos_route_s     o_pos_route,
	output logic      [NUM_CHAN-1:0]        o_chan_enable
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	typedef struct packed {
		logic       chan_hit;
		logic [3:0] chan;
		logic       pwr_hit;
		logic       status_hit;
	} addr_hit_s;

	function automatic addr_hit_s decode_addr(input logic [7:0] addr);
		addr_hit_s  h;
		logic [5:0] idx;
		logic [5:0] off;
		h          = '0;
		idx        = addr[7:2];
		off        = idx - `CCF_CHAN_BASE_IDX;
		if (addr[1:0] != 2'h0) begin
			h = '0;
		end else if (idx >= `CCF_CHAN_BASE_IDX && idx <= `CCF_CHAN_LAST_IDX &&
		             int'(off) < NUM_CHAN) begin
			h.chan_hit = 1'b1;
			h.chan     = off[3:0];
		end else if (idx == `CCF_PWR_CTRL_IDX) begin
			h.pwr_hit = 1'b1;
		end else if (idx == `CCF_STATUS_IDX) begin
			h.status_hit = 1'b1;
		end
		return h;
	endfunction : decode_addr

	// Status packing; the active-channel fields show what the pin and muxes use now
	function automatic logic [31:0] status_word(
		input logic                        sw_closed,
		input logic [1:0]                  pm,
		input logic [2:0]                  setup,
		input logic [4:0]                  pos,
		input channel_cfg_pkg::pos_route_s route
	);
		logic [31:0] w;
		w                                        = 32'h0000_0000;
		w[`CCF_ST_SW_BIT]                        = sw_closed;
		w[`CCF_ST_MODE_LSB+1:`CCF_ST_MODE_LSB]   = pm;
		w[`CCF_ST_SETUP_LSB+2:`CCF_ST_SETUP_LSB] = setup;
		w[`CCF_ST_POS_LSB+4:`CCF_ST_POS_LSB]     = pos;
		w[`CCF_ST_UNDEF_BIT] = (route.kind == channel_cfg_pkg::PK_UNDEFINED);
		return w;
	endfunction : status_word

	// Mode gating as one table; the channel bit never overrides power-down
	function automatic logic switch_closes(
		input channel_cfg_pkg::power_mode_e pm,
		input logic                         allow,
		input logic                         sw_bit,
		input logic                         converting
	);
		logic close;
		close = 1'b0;
		case (pm)
			channel_cfg_pkg::PM_ACTIVE: begin
				close = sw_bit && converting;
			end
			channel_cfg_pkg::PM_STANDBY: begin
				// Standby has no conversion running; the allowance bit gates the selected channel's bit
				close = allow && sw_bit;
			end
			default: close = 1'b0;
		endcase
		return close;
	endfunction : switch_closes

	////////////////////////////////////////////////////////////////////////////////
	// State

	channel_cfg_pkg::apb_state_e apb_st_q;
	channel_cfg_pkg::apb_state_e apb_st_d;
	logic [31:0]                 prdata_q;
	logic [31:0]                 prdata_d;
	logic                        pready_q;
	logic                        pready_d;
	logic                        pslverr_q;
	logic                        pslverr_d;
	logic [`CCF_CHAN_W-1:0]      chan_q [NUM_CHAN];
	logic [`CCF_CHAN_W-1:0]      chan_d [NUM_CHAN];
	logic [2:0]                  pwr_q;
	logic [2:0]                  pwr_d;

	logic                        switch_q;
	logic                        switch_d;
	logic [NUM_BANKS-1:0]        bank_q;
	logic [NUM_BANKS-1:0]        bank_d;
	logic [2:0]                  setup_q;
	logic [2:0]                  setup_d;
	logic [4:0]                  pos_q;
	logic [4:0]                  pos_d;
	channel_cfg_pkg::pos_route_s route_q;
	channel_cfg_pkg::pos_route_s route_d;
	logic [NUM_CHAN-1:0]         chen_q;
	logic [NUM_CHAN-1:0]         chen_d;

	addr_hit_s                   hit;
	logic                        mapped;
	logic [31:0]                 rd_data;
	logic [`CCF_CHAN_W-1:0]      act_cfg;
	logic                        act_valid;
	channel_cfg_pkg::power_mode_e mode;
	logic [NUM_BANKS-1:0]        bank_dec;
	channel_cfg_pkg::pos_route_s route_dec;

	assign hit    = decode_addr(i_paddr);
	assign mapped = hit.chan_hit | hit.pwr_hit | hit.status_hit;
	assign mode   = channel_cfg_pkg::power_mode_e'(pwr_q[`CCF_MODE_MSB:`CCF_MODE_LSB]);

	////////////////////////////////////////////////////////////////////////////////
	// Read mux

	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit.chan_hit) begin
			rd_data[`CCF_CHAN_W-1:0] = chan_q[hit.chan];
		end else if (hit.pwr_hit) begin
			rd_data[2:0] = pwr_q;
		end else if (hit.status_hit) begin
			rd_data = status_word(switch_q, pwr_q[`CCF_MODE_MSB:`CCF_MODE_LSB], setup_q, pos_q,
			                      route_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave and register file

	// One wait state: pready rises in the second access cycle, and the write lands on
	// the edge that samples it, so a held request never commits twice.
	always_comb begin
		apb_st_d  = apb_st_q;
		prdata_d  = prdata_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		pwr_d     = pwr_q;
		for (int c = 0; c < NUM_CHAN; c++) begin
			chan_d[c] = chan_q[c];
		end
		case (apb_st_q)
			channel_cfg_pkg::APB_IDLE: begin
				if (i_psel && !i_penable) begin
					apb_st_d = channel_cfg_pkg::APB_ACCESS;
				end
			end
			channel_cfg_pkg::APB_ACCESS: begin
				if (i_psel && i_penable) begin
					apb_st_d  = channel_cfg_pkg::APB_RESP;
					pready_d  = 1'b1;
					pslverr_d = !mapped;
					prdata_d  = i_pwrite ? 32'h0000_0000 : rd_data;
				end else if (!i_psel) begin
					apb_st_d = channel_cfg_pkg::APB_IDLE;
				end
			end
			channel_cfg_pkg::APB_RESP: begin
				apb_st_d = channel_cfg_pkg::APB_IDLE;
				if (i_psel && i_penable && i_pwrite) begin
					if (hit.chan_hit) begin
						// Reserved bit 18 is dropped on write so it always reads zero
						chan_d[hit.chan] = i_pwdata[`CCF_CHAN_W-1:0] & `CCF_CHAN_WR_MASK;
					end else if (hit.pwr_hit) begin
						pwr_d = i_pwdata[2:0];
					end
				end
			end
			default: apb_st_d = channel_cfg_pkg::APB_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			apb_st_q  <= channel_cfg_pkg::APB_IDLE;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			pwr_q     <= `CCF_PWR_CTRL_RST;
			for (int c = 0; c < NUM_CHAN; c++) begin
				chan_q[c] <= (c == 0) ? `CCF_CHAN0_RST : `CCF_CHANM_RST;
			end
		end else begin
			apb_st_q  <= apb_st_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			pwr_q     <= pwr_d;
			for (int c = 0; c < NUM_CHAN; c++) begin
				chan_q[c] <= chan_d[c];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Active channel decode

	// A channel number beyond the bank reads as an all-clear config, so the switch opens
	assign act_valid = (int'(i_active_chan) < NUM_CHAN);
	assign act_cfg   = act_valid ? chan_q[i_active_chan] : '0;

	setup_bank_decode #(
		.NUM_BANKS    (NUM_BANKS)
	) u_setup_bank_decode (
		.i_setup_code (act_cfg[`CCF_SETUP_MSB:`CCF_SETUP_LSB]),
		.o_bank_sel   (bank_dec)
	);

	positive_input_decode u_positive_input_decode (
		.i_code  (act_cfg[`CCF_POS_MSB:`CCF_POS_LSB]),
		.o_route (route_dec)
	);

	always_comb begin
		setup_d = act_cfg[`CCF_SETUP_MSB:`CCF_SETUP_LSB];
		bank_d  = bank_dec;
		pos_d   = act_cfg[`CCF_POS_MSB:`CCF_POS_LSB];
		route_d = route_dec;
		for (int c = 0; c < NUM_CHAN; c++) begin
			chen_d[c] = chan_q[c][`CCF_EN_BIT];
		end
		switch_d = switch_closes(mode, pwr_q[`CCF_ALLOW_BIT], act_cfg[`CCF_SW_BIT],
		                         i_chan_converting);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			switch_q <= 1'b0;
			bank_q   <= '0;
			setup_q  <= 3'h0;
			pos_q    <= 5'h00;
			route_q  <= '0;
			chen_q   <= '0;
		end else begin
			switch_q <= switch_d;
			bank_q   <= bank_d;
			setup_q  <= setup_d;
			pos_q    <= pos_d;
			route_q  <= route_d;
			chen_q   <= chen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_prdata                    = prdata_q;
	assign o_pready                    = pready_q;
	assign o_pslverr                   = pslverr_q;
	assign o_low_side_switch_pin_close = switch_q;
	assign o_setup_bank_sel            = bank_q;
	assign o_setup_code                = setup_q;
	assign o_positive_input_select     = pos_q;
	assign o_pos_route                 = route_q;
	assign o_chan_enable               = chen_q;

endmodule : channel_config_fields

`default_nettype wire

// >>> channel_cfg_defs.svh
// Constants for the channel configuration register bank: offsets, field positions, resets, codes.
// Assumes inclusion by bare name; holds definitions only.
`ifndef CHANNEL_CFG_DEFS_SVH
`define CHANNEL_CFG_DEFS_SVH

// Channel count and register indices; byte address is four times the index
`define CCF_NUM_CHAN          16
`define CCF_CHAN_BASE_IDX     6'h09
`define CCF_CHAN_LAST_IDX     6'h18
`define CCF_PWR_CTRL_IDX      6'h20
`define CCF_STATUS_IDX        6'h21

// Channel register layout
`define CCF_CHAN_W            24
`define CCF_CHAN0_RST         24'h800100
`define CCF_CHANM_RST         24'h000100
`define CCF_CHAN_WR_MASK      24'hfbffff
`define CCF_EN_BIT            23
`define CCF_SETUP_MSB         22
`define CCF_SETUP_LSB         20
`define CCF_SW_BIT            19
`define CCF_RSVD_BIT          18
`define CCF_POS_MSB           17
`define CCF_POS_LSB           13

// Power control register layout
`define CCF_PWR_CTRL_RST      3'h0
`define CCF_MODE_MSB          1
`define CCF_MODE_LSB          0
`define CCF_ALLOW_BIT         2

// Status register layout
`define CCF_ST_SW_BIT         0
`define CCF_ST_MODE_LSB       1
`define CCF_ST_SETUP_LSB      3
`define CCF_ST_POS_LSB        6
`define CCF_ST_UNDEF_BIT      11

// Positive input codes
`define CCF_POS_TEMP          5'h10
`define CCF_POS_AGND          5'h11
`define CCF_POS_REF           5'h12
`define CCF_POS_DIGITAL_GROUND_RAIL          5'h13
`define CCF_POS_ASUP_P        5'h14
`define CCF_POS_ASUP_N        5'h15
`define CCF_POS_IOSUP_P       5'h16
`define CCF_POS_IOSUP_N       5'h17
`define CCF_POS_AREG_P        5'h18
`define CCF_POS_AREG_N        5'h19
`define CCF_POS_DREG_P        5'h1a
`define CCF_POS_DREG_N        5'h1b
`define CCF_POS_MV_P          5'h1c
`define CCF_POS_MV_N          5'h1d

`endif

// >>> channel_cfg_pkg.sv
// Types shared by the channel configuration bank and its decoders.
// Assumes nothing beyond a SystemVerilog compiler.
package channel_cfg_pkg;

	typedef enum logic [1:0] {
		APB_IDLE   = 2'b00,
		APB_ACCESS = 2'b01,
		APB_RESP   = 2'b11
	} apb_state_e;

	typedef enum logic [1:0] {
		PM_ACTIVE     = 2'b00,
		PM_STANDBY    = 2'b01,
		PM_POWER_DOWN = 2'b10,
		PM_RESERVED   = 2'b11
	} power_mode_e;

	typedef enum logic [2:0] {
		PK_PIN            = 3'd0,
		PK_TEMP_SENSOR    = 3'd1,
		PK_ANALOG_GROUND  = 3'd2,
		PK_INT_REFERENCE  = 3'd3,
		PK_DIGITAL_GROUND = 3'd4,
		PK_SUPPLY_MONITOR = 3'd5,
		PK_TEST_SIGNAL    = 3'd6,
		PK_UNDEFINED      = 3'd7
	} pos_kind_e;

	typedef enum logic [1:0] {
		RAIL_ANALOG_SUPPLY      = 2'd0,
		RAIL_INTERFACE_SUPPLY   = 2'd1,
		RAIL_ANALOG_REGULATOR   = 2'd2,
		RAIL_DIGITAL_REGULATOR  = 2'd3
	} monitor_rail_e;

	typedef struct packed {
		pos_kind_e     kind;
		logic [2:0]    pin_index;
		monitor_rail_e rail;
		logic          negative_side;
	} pos_route_s;

endpackage : channel_cfg_pkg

// >>> setup_bank_decode.sv
// One-hot decode of a channel's setup-select code onto the setup banks.
// Assumes a settled code; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module setup_bank_decode #(
	parameter int NUM_BANKS = 8
) (
	input  wire logic [2:0]           i_setup_code,
	output var  logic [NUM_BANKS-1:0] o_bank_sel
);

	// Per-bit drivers go onto a net; the variable port then has a single driver
	wire logic [NUM_BANKS-1:0] sel;

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			assign sel[b] = (i_setup_code == 3'(b));
		end
	endgenerate

	assign o_bank_sel = sel;

endmodule : setup_bank_decode

`default_nettype wire

// >>> positive_input_decode.sv
// Decode of the positive-input select code into a crosspoint route description.
// Assumes the code comes from a register; purely combinational.
`timescale 1ns/1ns
`default_nettype none
`include "channel_cfg_defs.svh"

module positive_input_decode (
	input  wire logic [4:0]                 i_code,
	output var  channel_cfg_pkg::pos_route_s o_route
);

	always_comb begin
		o_route.kind          = channel_cfg_pkg::PK_UNDEFINED;
		o_route.pin_index     = 3'h0;
		o_route.rail          = channel_cfg_pkg::RAIL_ANALOG_SUPPLY;
		o_route.negative_side = i_code[0];
		if (i_code[4] == 1'b0) begin
			// Pin codes pair as 00x0x/01x1x patterns; the rest below 0x10 are unused
			case (i_code[3:1])
				3'h0: begin
					o_route.kind      = channel_cfg_pkg::PK_PIN;
					o_route.pin_index = {2'h0, i_code[0]};
				end
				3'h2: begin
					o_route.kind      = channel_cfg_pkg::PK_PIN;
					o_route.pin_index = {2'h1, i_code[0]};
				end
				3'h5: begin
					o_route.kind      = channel_cfg_pkg::PK_PIN;
					o_route.pin_index = {2'h2, i_code[0]};
				end
				3'h7: begin
					o_route.kind      = channel_cfg_pkg::PK_PIN;
					o_route.pin_index = {2'h3, i_code[0]};
				end
				default: o_route.kind = channel_cfg_pkg::PK_UNDEFINED;
			endcase
			o_route.negative_side = 1'b0;
		end else begin
			case (i_code)
				`CCF_POS_TEMP: o_route.kind = channel_cfg_pkg::PK_TEMP_SENSOR;
				`CCF_POS_AGND: o_route.kind = channel_cfg_pkg::PK_ANALOG_GROUND;
				`CCF_POS_REF:  o_route.kind = channel_cfg_pkg::PK_INT_REFERENCE;
				`CCF_POS_DIGITAL_GROUND_RAIL: o_route.kind = channel_cfg_pkg::PK_DIGITAL_GROUND;
				`CCF_POS_ASUP_P, `CCF_POS_ASUP_N: begin
					o_route.kind = channel_cfg_pkg::PK_SUPPLY_MONITOR;
					o_route.rail = channel_cfg_pkg::RAIL_ANALOG_SUPPLY;
				end
				`CCF_POS_IOSUP_P, `CCF_POS_IOSUP_N: begin
					o_route.kind = channel_cfg_pkg::PK_SUPPLY_MONITOR;
					o_route.rail = channel_cfg_pkg::RAIL_INTERFACE_SUPPLY;
				end
				`CCF_POS_AREG_P, `CCF_POS_AREG_N: begin
					o_route.kind = channel_cfg_pkg::PK_SUPPLY_MONITOR;
					o_route.rail = channel_cfg_pkg::RAIL_ANALOG_REGULATOR;
				end
				`CCF_POS_DREG_P, `CCF_POS_DREG_N: begin
					o_route.kind = channel_cfg_pkg::PK_SUPPLY_MONITOR;
					o_route.rail = channel_cfg_pkg::RAIL_DIGITAL_REGULATOR;
				end
				`CCF_POS_MV_P, `CCF_POS_MV_N: o_route.kind = channel_cfg_pkg::PK_TEST_SIGNAL;
				default: o_route.kind = channel_cfg_pkg::PK_UNDEFINED;
			endcase
			if (o_route.kind != channel_cfg_pkg::PK_SUPPLY_MONITOR &&
			    o_route.kind != channel_cfg_pkg::PK_TEST_SIGNAL) begin
				o_route.negative_side = 1'b0;
			end
		end
	end

endmodule : positive_input_decode

`default_nettype wire

// >>> channel_config_fields_chk.sv
// Checker for the channel configuration bank: switch gating, setup and input routing.
// Assumes it is bound to channel_config_fields and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "channel_cfg_defs.svh"

module channel_config_fields_chk #(
	parameter int NUM_CHAN  = 16,
	parameter int NUM_BANKS = 8
) (
	input wire logic                        i_core_clk,
	input wire logic                        i_sys_rst,
	input wire logic                        i_psel,
	input wire logic                        i_penable,
	input wire logic                        i_pwrite,
	input wire logic [7:0]                  i_paddr,
	input wire logic [31:0]                 i_pwdata,
	input wire logic [31:0]                 o_prdata,
	input wire logic                        o_pready,
	input wire logic                        o_pslverr,
	input wire logic [3:0]                  i_active_chan,
	input wire logic                        i_chan_converting,
	input wire logic                        o_low_side_switch_pin_close,
	input wire logic [NUM_BANKS-1:0]        o_setup_bank_sel,
	input wire logic [2:0]                  o_setup_code,
	input wire logic [4:0]                  o_positive_input_select,
	input wire channel_cfg_pkg::pos_route_s o_pos_route,
	input wire logic [NUM_CHAN-1:0]         o_chan_enable
);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the bank, captured at the edge where a write completes
	logic [23:0] chan_q [NUM_CHAN];
	logic [23:0] chan_d [NUM_CHAN];
	logic [2:0]  pwr_q;
	logic [2:0]  pwr_d;
	logic        wr;
	logic        sw_on;
	logic        close_exp;
	logic [2:0]  cur_setup;
	logic [4:0]  cur_pos;

	always_comb begin
		wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
		chan_d = chan_q;
		pwr_d = pwr_q;
		if (wr && i_paddr[7:2] >= `CCF_CHAN_BASE_IDX && i_paddr[7:2] <= `CCF_CHAN_LAST_IDX)
			chan_d[i_paddr[7:2] - `CCF_CHAN_BASE_IDX] = i_pwdata[23:0] & `CCF_CHAN_WR_MASK;
		if (wr && i_paddr[7:2] == `CCF_PWR_CTRL_IDX)
			pwr_d = i_pwdata[2:0];
		sw_on = chan_q[i_active_chan][`CCF_SW_BIT];
		cur_setup = chan_q[i_active_chan][22:20];
		cur_pos = chan_q[i_active_chan][17:13];
		case (pwr_q[1:0])
			2'h0: close_exp = sw_on && i_chan_converting;
			2'h1: close_exp = sw_on && pwr_q[2];
			default: close_exp = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < NUM_CHAN; i++)
				chan_q[i] <= (i == 0) ? `CCF_CHAN0_RST : `CCF_CHANM_RST;
			pwr_q <= 3'h0;
		end else begin
			chan_q <= chan_d;
			pwr_q <= pwr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	a_bank_onehot: assert property (!$past(i_sys_rst) |->
		o_setup_bank_sel == (NUM_BANKS'(1) << o_setup_code)) else $error("bank select wrong");
	a_setup_track: assert property (!$past(i_sys_rst) |->
		o_setup_code == $past(cur_setup)) else $error("setup code not of active channel");
	a_pos_track: assert property (!$past(i_sys_rst) |->
		o_positive_input_select == $past(cur_pos)) else $error("positive select wrong");
	a_active_close: assert property ($past(close_exp) |->
		o_low_side_switch_pin_close) else $error("switch not closed");
	a_clear_open: assert property (!$past(sw_on) |->
		!o_low_side_switch_pin_close) else $error("switch closed with bit clear");
	a_pdown_open: assert property ($past(pwr_q[1]) |->
		!o_low_side_switch_pin_close) else $error("switch closed in power-down");
	a_stby_gate: assert property ($past(pwr_q) == 3'h1 |->
		!o_low_side_switch_pin_close) else $error("switch closed in standby");
	a_asup_route: assert property (o_positive_input_select[4:1] == 4'ha |->
		o_pos_route.kind == channel_cfg_pkg::PK_SUPPLY_MONITOR
		&& o_pos_route.rail == channel_cfg_pkg::RAIL_ANALOG_SUPPLY
		&& o_pos_route.negative_side == o_positive_input_select[0]) else $error("route wrong");
	a_iosup_route: assert property (o_positive_input_select[4:1] == 4'hb |->
		o_pos_route.kind == channel_cfg_pkg::PK_SUPPLY_MONITOR
		&& o_pos_route.rail == channel_cfg_pkg::RAIL_INTERFACE_SUPPLY
		&& o_pos_route.negative_side == o_positive_input_select[0]) else $error("route wrong");
	a_areg_route: assert property (o_positive_input_select == 5'h18 |->
		o_pos_route.kind == channel_cfg_pkg::PK_SUPPLY_MONITOR
		&& o_pos_route.rail == channel_cfg_pkg::RAIL_ANALOG_REGULATOR
		&& !o_pos_route.negative_side) else $error("route wrong");

	c_stby_close: cover property (pwr_q[1:0] == 2'h1 && o_low_side_switch_pin_close);
	c_supply_route: cover property (o_pos_route.kind == channel_cfg_pkg::PK_SUPPLY_MONITOR);
	c_bus_error: cover property (o_pready && o_pslverr);
endmodule : channel_config_fields_chk
`default_nettype wire

// >>> tb_channel_config_fields.sv
// Self-checking bench for the channel configuration bank, driven over APB.
// Assumes the design answers each transfer with one wait state; checker bound below.
`timescale 1ns/1ns
`default_nettype none

module tb_channel_config_fields;
	logic                        i_core_clk        = 1'b0;
	logic                        i_sys_rst         = 1'b1;
	logic                        i_psel            = 1'b0;
	logic                        i_penable         = 1'b0;
	logic                        i_pwrite          = 1'b0;
	logic [7:0]                  i_paddr           = 8'h00;
	logic [31:0]                 i_pwdata          = 32'h0;
	logic [3:0]                  i_active_chan     = 4'h3;
	logic                        i_chan_converting = 1'b0;
	logic [31:0]                 o_prdata;
	logic                        o_pready;
	logic                        o_pslverr;
	logic                        o_low_side_switch_pin_close;
	logic [7:0]                  o_setup_bank_sel;
	logic [2:0]                  o_setup_code;
	logic [4:0]                  o_positive_input_select;
	channel_cfg_pkg::pos_route_s o_pos_route;
	logic [15:0]                 o_chan_enable;
	int                          mismatches        = 0;
	int                          tests_run         = 0;

	channel_config_fields #(.NUM_CHAN(16), .NUM_BANKS(8)) uut (.i_core_clk, .i_sys_rst,
		.i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
		.o_pslverr, .i_active_chan, .i_chan_converting, .o_low_side_switch_pin_close,
		.o_setup_bank_sel, .o_setup_code, .o_positive_input_select, .o_pos_route,
		.o_chan_enable);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_pready !== 1'b1);
		// One wait state is promised; a slower answer still completes but is reported
		check(n, 32'd2);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		check(rd, exp);
		check(e, exp_err);
	endtask : rd_chk

	// Derived outputs trail a completed write by one edge
	task automatic settle();
		repeat (3) @(posedge i_core_clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		rd_chk(8'h24, 32'h0080_0100, 1'b0);
		rd_chk(8'h60, 32'h0000_0100, 1'b0);
		check(o_setup_bank_sel, 32'h1);
		check(o_chan_enable, 32'h0000_0001);
		rd_chk(8'h70, 32'h0, 1'b1);
		rd_chk(8'h25, 32'h0, 1'b1);
	endtask : t_reset_values

	task automatic t_setup_banks();
		for (int c = 0; c < 8; c++) begin
			wr(8'h30, 32'(c) << 20);
			settle();
			check(o_setup_bank_sel, 32'h1 << c);
			check(o_setup_code, 32'(c));
		end
	endtask : t_setup_banks

	task automatic t_pos_codes();
		logic [5:0] key;
		for (int c = 0; c < 32; c++) begin
			// Software keeps away from reserved input codes
			if ((c < 16 && (c / 2) inside {1, 3, 4, 6}) || c >= 30) continue;
			// Reserved bit 18 is set on purpose; it must read back clear
			wr(8'h30, (32'(c) << 13) | 32'h0004_0000);
			rd_chk(8'h30, 32'(c) << 13, 1'b0);
			settle();
			check(o_positive_input_select, 32'(c));
			if (c == 15) check(o_pos_route.pin_index, 32'h7);
			key = {o_pos_route.kind, o_pos_route.rail, o_pos_route.negative_side};
			if (c / 2 == 10) check(key, {channel_cfg_pkg::PK_SUPPLY_MONITOR, 2'd0, c[0]});
			if (c / 2 == 11) check(key, {channel_cfg_pkg::PK_SUPPLY_MONITOR, 2'd1, c[0]});
			if (c == 24) check(key, {channel_cfg_pkg::PK_SUPPLY_MONITOR, 2'd2, 1'b0});
		end
	endtask : t_pos_codes

	task automatic t_switch();
		// Each entry: allowance, mode, switch bit, converting, expected switch state
		logic [5:0] tbl [8];
		tbl = '{6'b000111, 6'b000100, 6'b000010, 6'b001110,
			6'b101101, 6'b110110, 6'b111110, 6'b101010};
		foreach (tbl[i]) begin
			wr(8'h80, {29'd0, tbl[i][5:3]});
			wr(8'h30, {12'd0, tbl[i][2], 19'd0});
			i_chan_converting <= tbl[i][1];
			settle();
			check(o_low_side_switch_pin_close, tbl[i][0]);
		end
		wr(8'h80, 32'h0);
		wr(8'h30, 32'h0008_0000);
		i_chan_converting <= 1'b1;
		i_active_chan <= 4'h4;
		settle();
		check(o_low_side_switch_pin_close, 1'b0);
		i_active_chan <= 4'h3;
		settle();
		check(o_low_side_switch_pin_close, 1'b1);
		rd_chk(8'h84, 32'h0000_0001, 1'b0);
	endtask : t_switch

	task automatic print_verdict();
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #4 i_core_clk = ~i_core_clk;
	end

	initial begin
		repeat (12) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		t_reset_values();
		t_setup_banks();
		t_pos_codes();
		t_switch();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge i_core_clk);
		mismatches++;
		print_verdict();
	end
endmodule : tb_channel_config_fields

bind channel_config_fields channel_config_fields_chk #(.NUM_CHAN(NUM_CHAN),
	.NUM_BANKS(NUM_BANKS)) u_chk (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
	.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_active_chan,
	.i_chan_converting, .o_low_side_switch_pin_close, .o_setup_bank_sel, .o_setup_code,
	.o_positive_input_select, .o_pos_route, .o_chan_enable);
`default_nettype wire
